// file: pkg/bpc_defines.svh
`ifndef BPC_DEFINES_SVH
`define BPC_DEFINES_SVH

// ****************************************************************
// Byte offsets of the header registers in configuration space
// ****************************************************************
`define BPC_OFS_PREF_LIMIT_UP 8'h2C
`define BPC_OFS_IO_UPPER 8'h30
`define BPC_OFS_CAP_PTR 8'h34
`define BPC_OFS_ROM_BASE 8'h38
`define BPC_OFS_INT_LINE 8'h3C
`define BPC_OFS_INT_PIN 8'h3D
`define BPC_OFS_BRIDGE_CONTROL 8'h3E

// ****************************************************************
// Reset values, fixed read values and the bridge control write mask
// ****************************************************************
`define BPC_RST_PREF_LIMIT_UP 32'h0000_0000
`define BPC_RST_INT_PIN 8'h01
`define BPC_RST_BRIDGE_CONTROL 16'h0000
`define BPC_CAP_PTR_VAL 8'h50
`define BPC_INT_LINE_VAL 8'h00
`define BPC_BRIDGE_CONTROL_WR_MASK 16'h07FF

// ****************************************************************
// Field layouts and encodings
// ****************************************************************
`define BPC_PREF_CAP_64 4'h1
`define BPC_PIN_CODE_LSB 0
`define BPC_PIN_CODE_MSB 2
`define BPC_PIN_INTA 3'h1
`define BPC_PIN_INTD 3'h4

`endif

// file: pkg/bpc_pkg.sv
package bpc_pkg;

   // Kind of emulated interrupt message on the south-bridge link
   typedef enum logic {BPC_MSG_ASSERT, BPC_MSG_DEASSERT} bpc_msg_kind_e;

   // Emulated legacy interrupt lane, 0 = A up to 3 = D
   typedef logic [1:0] bpc_intx_t;

   // Message sender states
   typedef enum logic {BPC_EMU_IDLE, BPC_EMU_SEND} bpc_emu_state_e;

endpackage

// file: hdl/bpc_write_once_reg.sv
`timescale 1ns/100ps
// ****************************************************************
// Register that takes one software write and then holds
// ****************************************************************
module bpc_write_once_reg
#(
   parameter int W = 8,
   parameter logic [W-1:0] RST_VAL = '0
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wr_en,
   input wire logic [W-1:0] wr_data,
   output logic [W-1:0] value,
   output logic locked
);

   logic [W-1:0] value_next;
   logic locked_next;

   // First write loads and locks, later writes are dropped
   assign value_next = (wr_en && !locked) ? wr_data : value;
   assign locked_next = locked | wr_en;

   // Value and lock flops
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         value <= RST_VAL;
         locked <= 1'b0;
      end
      else
      begin
         value <= value_next;
         locked <= locked_next;
      end
   end

endmodule

// file: hdl/bpc_intx_emulator.sv
`timescale 1ns/100ps
`include "bpc_defines.svh"
// ****************************************************************
// Legacy interrupt emulation over the south-bridge link
// ****************************************************************
module bpc_intx_emulator
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic int_level,
   input wire logic [7:0] pin_code,
   input wire logic msg_ready,
   output logic msg_valid,
   output bpc_pkg::bpc_msg_kind_e msg_kind,
   output bpc_pkg::bpc_intx_t msg_intx
);
   import bpc_pkg::*;

   bpc_emu_state_e state_reg;
   bpc_emu_state_e state_next;
   logic sent_reg;
   logic sent_next;
   logic code_ok;
   logic want;
   logic launch;
   logic done;
   logic [2:0] code;
   bpc_intx_t lane;

   // Decode the pin code, reserved codes send nothing
   assign code = pin_code[`BPC_PIN_CODE_MSB:`BPC_PIN_CODE_LSB];
   assign code_ok = (pin_code[7:3] == 5'h00) && (code >= `BPC_PIN_INTA)
      && (code <= `BPC_PIN_INTD); // see R6
   assign lane = bpc_intx_t'(code - `BPC_PIN_INTA);
   assign want = int_level & code_ok;
   assign launch = (state_reg == BPC_EMU_IDLE) && (want != sent_reg); // see R8
   assign done = (state_reg == BPC_EMU_SEND) && msg_ready;

   // Next state
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         BPC_EMU_IDLE:
         begin
            if (launch)
               state_next = BPC_EMU_SEND;
         end
         BPC_EMU_SEND:
         begin
            if (msg_ready)
               state_next = BPC_EMU_IDLE;
         end
         default: state_next = BPC_EMU_IDLE;
      endcase
   end

   // Link state as last told to the far end
   assign sent_next = done ? (msg_kind == BPC_MSG_ASSERT) : sent_reg;

   // State flops
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         state_reg <= BPC_EMU_IDLE;
         sent_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         sent_reg <= sent_next;
      end
   end

   // Message flops, deassert reuses the lane of its assert
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         msg_valid <= 1'b0;
         msg_kind <= BPC_MSG_ASSERT;
         msg_intx <= '0;
      end
      else if (launch)
      begin
         msg_valid <= 1'b1; // see R8
         msg_kind <= want ? BPC_MSG_ASSERT : BPC_MSG_DEASSERT;
         msg_intx <= want ? lane : msg_intx;
      end
      else if (done)
         msg_valid <= 1'b0;
   end

endmodule

// file: hdl/bpc_config_header_regs.sv
`timescale 1ns/100ps
`include "bpc_defines.svh"
// Operation
// R1: Upper prefetchable limit, 32-bit read/write, reset zero, address bits 63:32.
// R2: Upper I/O base and limit not implemented; only 16-bit I/O decoded.
// R3: Capability pointer is read-only and returns 50h, the power-management structure.
// R4: No expansion ROM base register; the bridge is virtual.
// R5: Interrupt line is a read-only 8-bit register kept for compatibility.
// R6: Pin codes 1 to 4 select A to D, others reserved, reset 01h.
// R7: Interrupt pin takes one software write at boot, then holds.
// R8: Selected legacy interrupt is sent as assert/deassert messages on the link.
// R9: Bridge control register gives downstream and bridge-wide controls.
// R10: Upper limit is read/write with 64-bit capability, else reads zero.
// R11: Writes to read-only or missing registers ignored; missing ones read zero.
module bpc_config_header_regs
#(
   parameter logic [3:0] PREF_CAP = `BPC_PREF_CAP_64,
   parameter logic [15:0] BRIDGE_CONTROL_WR_MASK = `BPC_BRIDGE_CONTROL_WR_MASK
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cfg_wr,
   input wire logic cfg_rd,
   input wire logic [5:0] cfg_addr,
   input wire logic [3:0] cfg_be,
   input wire logic [31:0] cfg_wdata,
   output logic [31:0] cfg_rdata,
   output logic cfg_ack,
   output logic [31:0] prefetch_limit_upper,
   output logic [15:0] bridge_control,
   output logic [7:0] legacy_interrupt_select,
   input wire logic int_level,
   input wire logic msg_ready,
   output logic msg_valid,
   output bpc_pkg::bpc_msg_kind_e msg_kind,
   output bpc_pkg::bpc_intx_t msg_intx
);
   import bpc_pkg::*;

   // ****************************************************************
   // Address constants
   // ****************************************************************
   localparam logic [7:0] OFS_LIMIT = `BPC_OFS_PREF_LIMIT_UP;
   localparam logic [7:0] OFS_IO = `BPC_OFS_IO_UPPER;
   localparam logic [7:0] OFS_CAP = `BPC_OFS_CAP_PTR;
   localparam logic [7:0] OFS_ROM = `BPC_OFS_ROM_BASE;
   localparam logic [7:0] OFS_LINE = `BPC_OFS_INT_LINE;
   localparam logic [7:0] OFS_PIN = `BPC_OFS_INT_PIN;
   localparam logic [7:0] OFS_BRIDGE_CONTROL = `BPC_OFS_BRIDGE_CONTROL;

   // ****************************************************************
   // Decode
   // ****************************************************************
   logic pref64;
   logic hit_limit;
   logic hit_io;
   logic hit_cap;
   logic hit_rom;
   logic hit_int;
   logic wr_limit;
   logic wr_int;
   logic wr_pin;
   logic pin_locked;
   logic [15:0] bridge_control_lane_mask;
   logic [15:0] bridge_control_wr_bits;
   logic [31:0] limit_next;
   logic [15:0] bridge_control_next;
   logic [31:0] rd_word;
   logic [31:0] cfg_rdata_next;
   logic cfg_ack_next;

   // Word hits and write strobes
   assign pref64 = (PREF_CAP == `BPC_PREF_CAP_64);
   assign hit_limit = (cfg_addr == OFS_LIMIT[7:2]);
   assign hit_io = (cfg_addr == OFS_IO[7:2]);
   assign hit_cap = (cfg_addr == OFS_CAP[7:2]);
   assign hit_rom = (cfg_addr == OFS_ROM[7:2]);
   assign hit_int = (cfg_addr == OFS_LINE[7:2]);
   assign wr_limit = cfg_wr && hit_limit && pref64; // see R10
   assign wr_int = cfg_wr && hit_int;
   assign wr_pin = wr_int && cfg_be[OFS_PIN[1:0]]; // see R7

   // ****************************************************************
   // Upper prefetchable limit, byte-wise writes
   // ****************************************************************
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_limit_lane
         // One byte lane of the upper limit
         assign limit_next[gi*8 +: 8] = (wr_limit && cfg_be[gi]) ?
            cfg_wdata[gi*8 +: 8] : prefetch_limit_upper[gi*8 +: 8]; // see R1
      end
   endgenerate

   // Limit flop
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         prefetch_limit_upper <= `BPC_RST_PREF_LIMIT_UP; // see R1
      else
         prefetch_limit_upper <= limit_next;
   end

   // ****************************************************************
   // Bridge control, writable bits only
   // ****************************************************************
   assign bridge_control_lane_mask = {{8{cfg_be[OFS_BRIDGE_CONTROL[1:0] + 2'd1]}}, {8{cfg_be[OFS_BRIDGE_CONTROL[1:0]]}}};
   assign bridge_control_wr_bits = wr_int ? (bridge_control_lane_mask & BRIDGE_CONTROL_WR_MASK) : 16'h0000;
   assign bridge_control_next = (bridge_control & ~bridge_control_wr_bits)
      | (cfg_wdata[31:16] & bridge_control_wr_bits); // see R9

   // Bridge control flop
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         bridge_control <= `BPC_RST_BRIDGE_CONTROL;
      else
         bridge_control <= bridge_control_next;
   end

   // ****************************************************************
   // Interrupt pin, one write then held
   // ****************************************************************
   bpc_write_once_reg #(
      .W(8),
      .RST_VAL(`BPC_RST_INT_PIN)
   ) u_pin (
      .clk(clk),
      .rst_n(rst_n),
      .wr_en(wr_pin),
      .wr_data(cfg_wdata[15:8]),
      .value(legacy_interrupt_select), // see R6
      .locked(pin_locked)
   );

   // ****************************************************************
   // Legacy interrupt messages on the south-bridge link
   // ****************************************************************
   bpc_intx_emulator u_emu (
      .clk(clk),
      .rst_n(rst_n),
      .int_level(int_level),
      .pin_code(legacy_interrupt_select),
      .msg_ready(msg_ready),
      .msg_valid(msg_valid),
      .msg_kind(msg_kind),
      .msg_intx(msg_intx)
   );

   // ****************************************************************
   // Read path
   // ****************************************************************
   // Read mux, missing and unknown words give zero
   assign rd_word =
      hit_limit ? (pref64 ? prefetch_limit_upper : 32'h0000_0000) : // see R10
      hit_cap ? {24'h00_0000, `BPC_CAP_PTR_VAL} : // see R3
      hit_int ? {bridge_control, legacy_interrupt_select, `BPC_INT_LINE_VAL} : // see R5
      32'h0000_0000; // see R2 R4 R11
   assign cfg_rdata_next = cfg_rd ? rd_word : cfg_rdata;
   assign cfg_ack_next = cfg_rd | cfg_wr;

   // Answer flops
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         cfg_rdata <= 32'h0000_0000;
         cfg_ack <= 1'b0;
      end
      else
      begin
         cfg_rdata <= cfg_rdata_next;
         cfg_ack <= cfg_ack_next;
      end
   end

   // ****************************************************************
   // Link state as seen by the far end, for the checks below
   // ****************************************************************
   logic link_on_reg;
   logic link_on_next;

   // Follows every accepted message
   assign link_on_next = (msg_valid && msg_ready) ?
      (msg_kind == BPC_MSG_ASSERT) : link_on_reg;

   // Link state flop
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         link_on_reg <= 1'b0;
      else
         link_on_reg <= link_on_next;
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   // Reset values after release
   a_reset_values: assert property ( // see R1
      $past(!rst_n) |-> (prefetch_limit_upper == 32'h0000_0000)
         && (legacy_interrupt_select == 8'h01))
      else $error("limit or pin wrong after reset");

   // Full write lands in limit
   a_limit_write: assert property ( // see R1
      cfg_wr && hit_limit && (cfg_be == 4'hF) && pref64
         |=> prefetch_limit_upper == $past(cfg_wdata))
      else $error("limit write lost");

   // Limit readback depends on capability
   a_limit_read: assert property ( // see R10
      cfg_rd && !cfg_wr && hit_limit |=> cfg_ack
         && (cfg_rdata == (pref64 ? $past(prefetch_limit_upper) : 32'h0000_0000)))
      else $error("limit readback wrong");

   // Upper I/O word reads zero
   a_io_upper_zero: assert property ( // see R2
      cfg_rd && hit_io |=> cfg_rdata == 32'h0000_0000)
      else $error("upper io word not zero");

   // Capability pointer value
   a_capability_list_pointer_value: assert property ( // see R3
      cfg_rd && hit_cap |=> cfg_rdata == 32'h0000_0050)
      else $error("capability pointer wrong");

   // ROM base word reads zero
   a_rom_base_zero: assert property ( // see R4
      cfg_rd && hit_rom |=> cfg_rdata == 32'h0000_0000)
      else $error("rom base word not zero");

   // Interrupt word layout
   a_int_word_read: assert property ( // see R5
      cfg_rd && !cfg_wr && hit_int |=> (cfg_rdata[7:0] == 8'h00)
         && (cfg_rdata[15:8] == $past(legacy_interrupt_select))
         && (cfg_rdata[31:16] == $past(bridge_control)))
      else $error("interrupt word readback wrong");

   // Pin holds once written
   a_pin_write_once: assert property ( // see R7
      pin_locked |=> $stable(legacy_interrupt_select) [*2])
      else $error("pin changed after first write");

   // First pin write taken
   a_pin_first_write: assert property ( // see R6
      wr_pin && !pin_locked |=> legacy_interrupt_select == $past(cfg_wdata[15:8]))
      else $error("first pin write lost");

   // Bridge control write
   a_bridge_control_write: assert property ( // see R9
      wr_int && (cfg_be[3:2] == 2'b11)
         |=> bridge_control == ($past(cfg_wdata[31:16]) & BRIDGE_CONTROL_WR_MASK))
      else $error("bridge control write wrong");

   // Writes elsewhere change nothing
   a_ro_write_ignored: assert property ( // see R11
      cfg_wr && !hit_limit && !hit_int |=> $stable(prefetch_limit_upper)
         && $stable(bridge_control) && $stable(legacy_interrupt_select))
      else $error("write to read-only word changed state");

   // Assert message raised after interrupt level
   a_msg_follows_level: assert property ( // see R8
      !msg_valid && int_level && (legacy_interrupt_select == 8'h01) && !link_on_reg
         |=> msg_valid && (msg_kind == BPC_MSG_ASSERT) && (msg_intx == 2'h0))
      else $error("no assert message for raised interrupt");

   // Every request answered next cycle
   a_ack_follows: assert property ( // see R11
      (cfg_rd || cfg_wr) |=> cfg_ack)
      else $error("request not acknowledged");

   // No answer without a request
   a_ack_idle: assert property ( // see R11
      !cfg_rd && !cfg_wr |=> !cfg_ack)
      else $error("acknowledge without request");

   // Read data held between reads
   a_rdata_holds: assert property ( // see R11
      !cfg_rd |=> $stable(cfg_rdata))
      else $error("read data changed without read");

   // Message and its fields held until taken
   a_msg_holds: assert property ( // see R8
      msg_valid && !msg_ready |=> msg_valid && $stable(msg_kind) && $stable(msg_intx))
      else $error("message dropped before acceptance");

   // One idle cycle after each accepted message
   a_msg_spacing: assert property ( // see R8
      msg_valid && msg_ready |=> !msg_valid)
      else $error("message not released after acceptance");

   // Reserved pin code sends nothing
   a_reserved_silent: assert property ( // see R6
      !msg_valid && !link_on_reg && (legacy_interrupt_select == 8'h05) |=> !msg_valid)
      else $error("message sent for reserved pin code");

   // Pin locks on its first write
   a_pin_locks: assert property ( // see R7
      wr_pin |=> pin_locked)
      else $error("pin not locked after write");

   // Fixed bridge control bits stay zero
   a_bridge_control_fixed_zero: assert property ( // see R9
      (bridge_control & ~BRIDGE_CONTROL_WR_MASK) == 16'h0000)
      else $error("fixed bridge control bit set");

   // Main scenarios
   c_limit_written: cover property (wr_limit && (cfg_be == 4'hF));
   c_pin_locked: cover property (wr_pin ##1 pin_locked ##[1:20] wr_pin);
   c_msg_assert: cover property (msg_valid && msg_ready && (msg_kind == BPC_MSG_ASSERT));
   c_msg_deassert: cover property (msg_valid && msg_ready && (msg_kind == BPC_MSG_DEASSERT));

endmodule

// file: dv/bpc_link_sink.sv
`timescale 1ns/100ps
// ****************************************************************
// South-bridge link receiver for emulated interrupt messages
// ****************************************************************
module bpc_link_sink
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic slow,
   input wire logic msg_valid,
   input wire bpc_pkg::bpc_msg_kind_e msg_kind,
   input wire bpc_pkg::bpc_intx_t msg_intx,
   output logic msg_ready,
   output logic [7:0] msg_count,
   output bpc_pkg::bpc_msg_kind_e last_kind,
   output bpc_pkg::bpc_intx_t last_intx,
   output logic proto_err
);
   import bpc_pkg::*;
   logic [1:0] wait_cnt;

   // Idle receiver, first message must be an assert
   initial
   begin
      msg_ready = 1'b0;
      msg_count = 8'h00;
      last_kind = BPC_MSG_DEASSERT;
      last_intx = 2'h0;
      proto_err = 1'b0;
      wait_cnt = 2'h0;
   end

   // Take a message at the accepting edge, check alternation and lane
   always @(posedge clk)
   begin
      if (rst_n && msg_valid && msg_ready)
      begin
         if (msg_kind == last_kind || (msg_kind == BPC_MSG_DEASSERT && msg_intx != last_intx))
            proto_err <= 1'b1;
         msg_count <= msg_count + 8'h01;
         last_kind <= msg_kind;
         last_intx <= msg_intx;
      end
   end

   // Ready after zero or three idle cycles, one cycle wide
   always @(negedge clk)
   begin
      if (!rst_n || msg_ready)
      begin
         msg_ready <= 1'b0;
         wait_cnt <= slow ? 2'h3 : 2'h0;
      end
      else if (msg_valid)
      begin
         if (wait_cnt == 2'h0)
            msg_ready <= 1'b1;
         else
            wait_cnt <= wait_cnt - 2'h1;
      end
   end
endmodule

// file: dv/bridge_port_config_header_regs_tb.sv
`timescale 1ns/100ps
`include "bpc_defines.svh"
// ****************************************************************
// Configuration header register bench
// ****************************************************************
module bridge_port_config_header_regs_tb;
   import bpc_pkg::*;
   logic clk, rst_n, cfg_wr, cfg_rd, cfg_ack, int_level, msg_ready, msg_valid, slow, proto_err;
   logic [5:0] cfg_addr;
   logic [3:0] cfg_be;
   logic [31:0] cfg_wdata, cfg_rdata, rdata_z, prefetch_limit_upper;
   logic [15:0] bridge_control;
   logic [7:0] legacy_interrupt_select, msg_count, n, pin;
   bpc_msg_kind_e msg_kind, last_kind;
   bpc_intx_t msg_intx, last_intx;
   int num_errors = 0;
   int samples_checked = 0;
   int cycles = 0;

   bpc_config_header_regs i_dut (.clk(clk), .rst_n(rst_n), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
      .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
      .cfg_ack(cfg_ack), .prefetch_limit_upper(prefetch_limit_upper),
      .bridge_control(bridge_control), .legacy_interrupt_select(legacy_interrupt_select),
      .int_level(int_level), .msg_ready(msg_ready), .msg_valid(msg_valid),
      .msg_kind(msg_kind), .msg_intx(msg_intx));
   // Same bus on a port with 32-bit prefetch only
   bpc_config_header_regs #(.PREF_CAP(4'h0)) i_dut_narrow (.clk(clk), .rst_n(rst_n),
      .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
      .cfg_wdata(cfg_wdata), .cfg_rdata(rdata_z), .cfg_ack(), .prefetch_limit_upper(),
      .bridge_control(), .legacy_interrupt_select(), .int_level(int_level),
      .msg_ready(1'b1), .msg_valid(), .msg_kind(), .msg_intx());
   bpc_link_sink i_sink (.clk(clk), .rst_n(rst_n), .slow(slow), .msg_valid(msg_valid),
      .msg_kind(msg_kind), .msg_intx(msg_intx), .msg_ready(msg_ready), .msg_count(msg_count),
      .last_kind(last_kind), .last_intx(last_intx), .proto_err(proto_err));

   // Clock of 50 ns
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
   begin
      samples_checked = samples_checked + 1;
      if (seen !== exp)
      begin
         num_errors = num_errors + 1;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   end
   endtask

   task stop_test;
   begin
      $display("errors %0d, checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   end
   endtask

   // One write, acknowledged one cycle later
   task cfg_write(input logic [7:0] ofs, input logic [3:0] be, input logic [31:0] data);
   begin
      cfg_wr = 1'b1;
      cfg_addr = ofs[7:2];
      cfg_be = be;
      cfg_wdata = data;
      @(negedge clk);
      check("write ack", {31'h0, cfg_ack}, 32'h0000_0001);
      cfg_wr = 1'b0;
      @(negedge clk);
   end
   endtask

   // One read, data in the acknowledge cycle
   task cfg_read(input logic [7:0] ofs, input logic [31:0] exp);
   begin
      cfg_rd = 1'b1;
      cfg_addr = ofs[7:2];
      @(negedge clk);
      check("read ack", {31'h0, cfg_ack}, 32'h0000_0001);
      check("read data", cfg_rdata, exp);
      cfg_rd = 1'b0;
      @(negedge clk);
   end
   endtask

   // Wait for the receiver count to reach a value, bounded
   task wait_msg(input logic [7:0] target);
   begin
      for (int k = 0; k < 20 && msg_count !== target; k++)
         @(negedge clk);
   end
   endtask

   // Hang guard
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         num_errors = num_errors + 1;
         stop_test;
      end
   end

   // Main sequence
   initial
   begin
      rst_n = 1'b0;
      cfg_wr = 1'b0;
      cfg_rd = 1'b0;
      cfg_addr = 6'h00;
      cfg_be = 4'h0;
      cfg_wdata = 32'h0000_0000;
      int_level = 1'b0;
      slow = 1'b0;
      repeat (10) @(negedge clk);
      rst_n = 1'b1;
      cfg_read(`BPC_OFS_PREF_LIMIT_UP, 32'h0000_0000);
      cfg_read(`BPC_OFS_CAP_PTR, 32'h0000_0050);
      cfg_read(`BPC_OFS_INT_LINE, 32'h0000_0100);
      check("pin port", {24'h0, legacy_interrupt_select}, 32'h0000_0001);
      // Full and single-lane limit writes
      cfg_write(`BPC_OFS_PREF_LIMIT_UP, 4'hF, 32'hA5C3_0F96);
      cfg_write(`BPC_OFS_PREF_LIMIT_UP, 4'h2, 32'hFFFF_77FF);
      cfg_read(`BPC_OFS_PREF_LIMIT_UP, 32'hA5C3_7796);
      check("limit port", prefetch_limit_upper, 32'hA5C3_7796);
      check("narrow limit", rdata_z, 32'h0000_0000);
      // Missing and read-only places
      cfg_write(`BPC_OFS_IO_UPPER, 4'hF, 32'hFFFF_FFFF);
      cfg_write(`BPC_OFS_ROM_BASE, 4'hF, 32'hFFFF_FFFF);
      cfg_write(`BPC_OFS_CAP_PTR, 4'hF, 32'hFFFF_FFFF);
      cfg_read(`BPC_OFS_IO_UPPER, 32'h0000_0000);
      cfg_read(`BPC_OFS_ROM_BASE, 32'h0000_0000);
      cfg_read(`BPC_OFS_CAP_PTR, 32'h0000_0050);
      cfg_read(8'h00, 32'h0000_0000);
      // Every pin code once per reset, then a reserved one
      for (pin = 8'h01; pin <= 8'h05; pin++)
      begin
         rst_n = 1'b0;
         repeat (2) @(negedge clk);
         rst_n = 1'b1;
         slow = pin[0];
         cfg_read(`BPC_OFS_PREF_LIMIT_UP, 32'h0000_0000);
         cfg_write(`BPC_OFS_INT_LINE, 4'hF, {16'hFFFF, pin, 8'hFF});
         check("bridge_control port", {16'h0, bridge_control}, 32'h0000_07FF);
         cfg_write(`BPC_OFS_INT_LINE, 4'hE, {16'h0123, 8'h06, 8'h00});
         cfg_read(`BPC_OFS_INT_LINE, {16'h0123, pin, 8'h00});
         n = msg_count;
         int_level = 1'b1;
         wait_msg(n + 8'h01);
         if (pin < 8'h05)
         begin
            check("assert kind", 32'(last_kind), 32'(BPC_MSG_ASSERT));
            check("assert lane", 32'(last_intx), 32'(pin) - 32'h1);
            int_level = 1'b0;
            wait_msg(n + 8'h02);
            check("deassert kind", 32'(last_kind), 32'(BPC_MSG_DEASSERT));
            check("deassert lane", 32'(last_intx), 32'(pin) - 32'h1);
         end
         else
            check("reserved count", {24'h0, msg_count}, {24'h0, n});
      end
      check("link order", {31'h0, proto_err}, 32'h0000_0000);
      stop_test;
   end
endmodule
